/* File: rtl/imr_pkg.sv */
// constants and types of the message-in status reporter
package imr_pkg;
	// code and step pair given to the host
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] step;
	} imr_rep_s;
	// raw scsi bus lines, active low as on the cable
	typedef struct packed {
		logic rst_n;
		logic bsy_n;
		logic sel_n;
		logic req_n;
		logic msg_n;
		logic cd_n;
		logic io_n;
		logic dbp_n;
		logic [7:0] db_n;
	} imr_pins_s;
	localparam logic [7:0] CODE_RESET = 8'h01;
	localparam logic [7:0] CODE_PARITY = 8'h24;
	localparam logic [7:0] CODE_TIMEOUT = 8'h2c;
	localparam logic [7:0] CODE_FREE_MID = 8'h31;
	localparam logic [7:0] CODE_PHASE_CHG = 8'h32;
	localparam logic [7:0] CODE_BAD_PHASE = 8'h54;
	localparam logic [7:0] CODE_STATUS_IN = 8'h56;
	localparam logic [7:0] CODE_DONE = 8'h60;
	localparam logic [7:0] CODE_DOUBLE = 8'h64;
	localparam logic [7:0] CODE_REJECT = 8'h65;
	localparam logic [7:0] CODE_REG_PARITY = 8'h66;
	localparam logic [7:0] CODE_FREE = 8'h70;
	localparam logic [7:0] STEP_0 = 8'h00;
	localparam logic [7:0] STEP_1 = 8'h01;
	localparam logic [7:0] STEP_2 = 8'h02;
	// host command codes
	localparam logic [7:0] CMD_RECV_MSG = 8'h1a;
	localparam logic [7:0] CMD_SELECT = 8'h20;
	localparam logic [7:0] CMD_SET_ATN = 8'h60;
	localparam logic [7:0] CMD_RESET_ATN = 8'h61;
	localparam logic [7:0] CMD_SET_ACK = 8'h62;
	localparam logic [7:0] CMD_RESET_ACK = 8'h63;
	localparam logic [7:0] CMD_TARGET_MASK = 8'hc0;
	localparam logic [7:0] CMD_TARGET_BASE = 8'h80;
	typedef enum logic [2:0] {CLS_UNDEF, CLS_XFER, CLS_SEL, CLS_DISC, CLS_TARGET} imr_cls_e;
	// {msg, c/d, i/o} as true levels
	localparam logic [2:0] PH_MSG_IN = 3'h7;
	localparam logic [2:0] PH_STATUS = 3'h3;
	localparam int CLK_PERIOD_NS = 4;
	localparam int REQACK_TIMEOUT_NS = 1000;
	localparam int TIMEOUT_CYC = (REQACK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH = 32;
	localparam int DATA_W = 8;
endpackage

/* File: rtl/imr_top.sv */
// message-in receive engine, status reporter and receive fifo
// Operation
// RULE1: bus reset reports 01, step by progress
// RULE2: input parity error reports 24/01; the auto-received status byte is not parity checked
// RULE3: req/ack timeout reports 2c/01
// RULE4: bus free mid-transfer reports 31/01
// RULE5: phase change mid-transfer reports 32/01
// RULE6: those three end command immediately
// RULE7: first req not message in: 54/01
// RULE8: auto receive of one status: 56/01
// RULE9: normal completion reports 60/02
// RULE10: zero byte count reports 65/01
// RULE11: bus free before 70/00, after 70/02
// RULE12: free with held ack reports 31/00
// RULE13: double command: result first, then 64/00; 64/00 is queued only when the result goes straight into cur_reg
// RULE14: pending ready cause first, then 64/00
// RULE15: target command as initiator: 65/00
// RULE16: undefined command reports 65/00
// RULE17: nexus mismatch with command reports 65/00
// RULE18: register parity error reports 66/00
// RULE19: every report raises interrupt until read; with the queue full a newer report overwrites the one in nxt_reg
`timescale 1ns/1ns
module imr_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_reg;
	logic [AW:0] rd_reg;
	assign in_ready = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
	assign out_valid = wr_reg != rd_reg;
	assign out_data = mem[rd_reg[AW-1:0]];
	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_reg <= rd_reg + 1'b1;
			end
		end
	end
endmodule

module imr_top #(
	parameter int TIMEOUT = imr_pkg::TIMEOUT_CYC,
	parameter int DEPTH = imr_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// host command
	input wire logic CMD_STB,
	input wire logic [7:0] CMD_CODE,
	input wire logic CMD_REG_PERR,
	input wire logic [7:0] MSG_COUNT,
	input wire logic AUTO_RECV,
	input wire logic MANUAL_ACK,
	input wire logic INITIATOR,
	input wire logic NEXUS,
	output logic SEL_GO,
	// report to host
	output logic INT_REQ,
	output imr_pkg::imr_rep_s REPORT,
	input wire logic INT_ACK,
	// scsi bus
	input wire imr_pkg::imr_pins_s SCSI_IN,
	output logic SCSI_ACK_OE,
	// received bytes
	output logic [imr_pkg::DATA_W-1:0] RX_DATA,
	output logic RX_VALID,
	input wire logic RX_READY
);
	import imr_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_FIRST = 3'h1, ST_XFER = 3'h3, ST_ACKW = 3'h2,
		ST_HOLD = 3'h6, ST_STAT = 3'h4
	} imr_st_e;

	function automatic imr_cls_e cmd_class(input logic [7:0] c);
		if ((c & CMD_TARGET_MASK) == CMD_TARGET_BASE) begin
			return CLS_TARGET;
		end
		case (c)
			CMD_RECV_MSG: return CLS_XFER;
			CMD_SELECT: return CLS_SEL;
			CMD_SET_ATN, CMD_RESET_ATN, CMD_SET_ACK, CMD_RESET_ACK: return CLS_DISC;
			default: return CLS_UNDEF;
		endcase
	endfunction

	function automatic imr_rep_s rep(input logic [7:0] c, input logic [7:0] s);
		return '{code: c, step: s};
	endfunction

	// two-flop synchroniser for every bus line
	imr_pins_s s1_reg, s2_reg;
	always_ff @(posedge CLK) begin
		s1_reg <= SCSI_IN;
		s2_reg <= s1_reg;
	end
	logic b_rst, b_free, b_req, par_ok;
	logic [2:0] b_phase;
	logic [7:0] b_data;
	assign b_rst = !s2_reg.rst_n;
	assign b_free = s2_reg.bsy_n && s2_reg.sel_n;
	assign b_req = !s2_reg.req_n;
	assign b_phase = {!s2_reg.msg_n, !s2_reg.cd_n, !s2_reg.io_n};
	assign b_data = ~s2_reg.db_n;
	// odd parity over data and parity bit
	assign par_ok = ^{b_data, !s2_reg.dbp_n};

	imr_st_e state_reg, state_next;
	logic [7:0] count_reg;
	logic [$clog2(TIMEOUT+1)-1:0] tmo_reg;
	logic ack_reg, ack_next, dbl_reg, sel_reg;
	logic post_v, post_ready;
	imr_rep_s post_rep;
	logic push_v, fifo_in_ready;
	imr_rep_s cur_reg, nxt_reg;
	logic int_reg, nxt_v_reg, cur_ready_reg;
	logic busy, last, tmo_hit, cmd_take;
	imr_cls_e cls;

	assign busy = state_reg != ST_IDLE && state_reg != ST_HOLD;
	assign last = count_reg == 8'h01;
	assign tmo_hit = tmo_reg == ($clog2(TIMEOUT+1))'(TIMEOUT);
	assign cls = cmd_class(CMD_CODE);
	assign cmd_take = CMD_STB && !busy && !(int_reg && cur_ready_reg);

	always_comb begin
		state_next = state_reg;
		ack_next = ack_reg;
		post_v = 1'b0;
		post_ready = 1'b0;
		post_rep = rep(CODE_DONE, STEP_2);
		push_v = 1'b0;
		case (state_reg)
			ST_IDLE, ST_HOLD: begin
				if (b_rst && state_reg == ST_HOLD) begin
					post_v = 1'b1;
					post_ready = 1'b1;
					post_rep = rep(CODE_RESET, STEP_0);
					state_next = ST_IDLE;
					ack_next = 1'b0;
				end else if (b_free && state_reg == ST_HOLD) begin
					post_v = 1'b1; // [RULE12]
					post_ready = 1'b1;
					post_rep = rep(CODE_FREE_MID, STEP_0); // [RULE12]
					state_next = ST_IDLE;
					ack_next = 1'b0;
				end else if (CMD_STB && int_reg && cur_ready_reg) begin
					post_v = 1'b1;
					post_rep = rep(CODE_DOUBLE, STEP_0); // [RULE14]
				end else if (cmd_take) begin
					post_v = 1'b1;
					post_rep = rep(CODE_REJECT, STEP_0);
					if (CMD_REG_PERR) begin
						post_rep = rep(CODE_REG_PARITY, STEP_0); // [RULE18]
					end else if (cls == CLS_TARGET || cls == CLS_UNDEF) begin
						post_rep = rep(CODE_REJECT, STEP_0); // [RULE15] [RULE16]
					end else if ((cls == CLS_XFER && !NEXUS) || (cls == CLS_SEL && NEXUS)) begin
						post_rep = rep(CODE_REJECT, STEP_0); // [RULE17]
					end else if (cls == CLS_SEL) begin
						post_v = 1'b0;
					end else if (cls == CLS_DISC) begin
						post_rep = rep(CODE_DONE, STEP_1);
						if (CMD_CODE == CMD_RESET_ACK) begin
							ack_next = 1'b0;
							state_next = ST_IDLE;
						end
					end else if (MSG_COUNT == 8'h00) begin
						post_rep = rep(CODE_REJECT, STEP_1); // [RULE10]
					end else begin
						post_v = 1'b0;
						ack_next = 1'b0;
						state_next = ST_FIRST;
					end
				end else if (b_rst && state_reg == ST_IDLE && !(int_reg && cur_ready_reg)) begin
					post_v = 1'b1;
					post_ready = 1'b1;
					post_rep = rep(CODE_RESET, STEP_0);
				end
			end
			ST_FIRST, ST_XFER, ST_ACKW, ST_STAT: begin
				post_v = 1'b1;
				state_next = ST_IDLE;
				ack_next = 1'b0;
				if (b_rst) begin
					post_rep = rep(CODE_RESET, state_reg == ST_FIRST ? STEP_0 :
						(state_reg == ST_ACKW && last) ? STEP_2 : STEP_1); // [RULE1]
				end else if (b_free) begin
					if (state_reg == ST_FIRST) begin
						post_rep = rep(CODE_FREE, STEP_0); // [RULE11]
					end else if (state_reg == ST_ACKW && last) begin
						post_rep = rep(CODE_FREE, STEP_2); // [RULE11]
					end else begin
						post_rep = rep(CODE_FREE_MID, STEP_1); // [RULE4] [RULE6]
					end
				end else if (tmo_hit) begin
					post_rep = rep(CODE_TIMEOUT, STEP_1); // [RULE3] [RULE6]
				end else if (state_reg == ST_ACKW || state_reg == ST_STAT) begin
					post_v = 1'b0;
					state_next = state_reg;
					ack_next = 1'b1;
					if (!b_req) begin
						ack_next = 1'b0;
						state_next = ST_XFER;
						if (state_reg == ST_STAT) begin
							post_v = 1'b1;
							post_rep = rep(CODE_STATUS_IN, STEP_1); // [RULE8]
							state_next = ST_IDLE;
						end else if (last) begin
							post_v = 1'b1;
							post_rep = rep(CODE_DONE, STEP_2); // [RULE9]
							ack_next = MANUAL_ACK;
							state_next = MANUAL_ACK ? ST_HOLD : ST_IDLE;
						end
					end
				end else if (!b_req) begin
					post_v = 1'b0;
					state_next = state_reg;
				end else if (b_phase != PH_MSG_IN) begin
					if (state_reg == ST_XFER) begin
						post_rep = rep(CODE_PHASE_CHG, STEP_1); // [RULE5] [RULE6]
					end else if (AUTO_RECV && b_phase == PH_STATUS) begin
						post_v = 1'b0;
						ack_next = fifo_in_ready;
						push_v = fifo_in_ready;
						state_next = fifo_in_ready ? ST_STAT : ST_FIRST;
					end else begin
						post_rep = rep(CODE_BAD_PHASE, STEP_1); // [RULE7]
					end
				end else if (!par_ok) begin
					post_rep = rep(CODE_PARITY, STEP_1); // [RULE2]
				end else begin
					// a full fifo holds off ack, pushing back on the target
					post_v = 1'b0;
					ack_next = fifo_in_ready;
					push_v = fifo_in_ready;
					state_next = fifo_in_ready ? ST_ACKW : state_reg;
				end
			end
			default: begin
				state_next = ST_IDLE;
				ack_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			ack_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ack_reg <= ack_next;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			count_reg <= 8'h00;
		end else if (cmd_take && state_next == ST_FIRST) begin
			count_reg <= MSG_COUNT;
		end else if (state_reg == ST_ACKW && !b_req && !last) begin
			count_reg <= count_reg - 8'h01;
		end
	end

	// timer restarts on every step and while the fifo stalls
	always_ff @(posedge CLK) begin
		if (RST || !busy || state_next != state_reg || (b_req && !fifo_in_ready)) begin
			tmo_reg <= '0;
		end else if (!tmo_hit) begin
			tmo_reg <= tmo_reg + 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			dbl_reg <= 1'b0;
		end else if (CMD_STB && busy) begin
			dbl_reg <= 1'b1; // [RULE13]
		end else if (post_v && busy) begin
			dbl_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			sel_reg <= 1'b0;
		end else begin
			sel_reg <= cmd_take && !CMD_REG_PERR && cls == CLS_SEL && !NEXUS;
		end
	end

	// two-deep report queue; a new report beats the host's read
	logic q_free, post64;
	assign q_free = !int_reg || INT_ACK;
	assign post64 = post_v && busy && dbl_reg;
	always_ff @(posedge CLK) begin
		if (RST) begin
			cur_reg <= rep(CODE_DONE, STEP_0);
			nxt_reg <= rep(CODE_DONE, STEP_0);
			int_reg <= 1'b0;
			nxt_v_reg <= 1'b0;
			cur_ready_reg <= 1'b0;
		end else if (post_v) begin
			if (q_free && !nxt_v_reg) begin
				cur_reg <= post_rep; // [RULE19]
				cur_ready_reg <= post_ready;
				int_reg <= 1'b1; // [RULE19]
				nxt_reg <= rep(CODE_DOUBLE, STEP_0); // [RULE13]
				nxt_v_reg <= post64;
			end else if (q_free) begin
				cur_reg <= nxt_reg;
				cur_ready_reg <= 1'b0;
				nxt_reg <= post_rep;
			end else begin
				// full queue: the newest report overwrites whichever report waits in nxt_reg
				nxt_reg <= post_rep;
				nxt_v_reg <= 1'b1;
			end
		end else if (int_reg && INT_ACK) begin
			if (nxt_v_reg) begin
				cur_reg <= nxt_reg;
				cur_ready_reg <= 1'b0;
				nxt_v_reg <= 1'b0;
			end else begin
				int_reg <= 1'b0;
			end
		end
	end

	// output stage keeps rx outputs on flops
	logic [DATA_W-1:0] f_data, rx_data_reg;
	logic f_valid, f_ready, rx_valid_reg;
	assign f_ready = !rx_valid_reg || RX_READY;
	imr_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_data(b_data),
		.in_valid(push_v),
		.in_ready(fifo_in_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);
	always_ff @(posedge CLK) begin
		if (RST) begin
			rx_valid_reg <= 1'b0;
			rx_data_reg <= '0;
		end else if (f_ready) begin
			rx_valid_reg <= f_valid;
			rx_data_reg <= f_data;
		end
	end

	assign SCSI_ACK_OE = ack_reg;
	assign INT_REQ = int_reg;
	assign REPORT = cur_reg;
	assign SEL_GO = sel_reg;
	assign RX_DATA = rx_data_reg;
	assign RX_VALID = rx_valid_reg;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	logic q_empty;
	assign q_empty = !int_reg && !nxt_v_reg;

	AST_RESET_FIRST: assert property (state_reg == ST_FIRST && b_rst && q_empty |=> // [RULE1]
		int_reg && cur_reg.code == CODE_RESET && cur_reg.step == STEP_0 && state_reg == ST_IDLE)
		else $error("reset before transfer misreported");
	AST_PARITY: assert property ((state_reg == ST_FIRST || state_reg == ST_XFER) && b_req // [RULE2]
		&& b_phase == PH_MSG_IN && !par_ok
		&& !b_rst && !b_free && !tmo_hit && q_empty |=> cur_reg == rep(CODE_PARITY, STEP_1))
		else $error("parity error not reported");
	AST_TIMEOUT: assert property (busy && tmo_hit && !b_rst && !b_free && q_empty |=> // [RULE3]
		int_reg && cur_reg == rep(CODE_TIMEOUT, STEP_1))
		else $error("timeout not reported");
	AST_FREE_MID: assert property (state_reg == ST_XFER && b_free && !b_rst && q_empty |=> // [RULE4]
		cur_reg == rep(CODE_FREE_MID, STEP_1))
		else $error("bus free mid transfer misreported");
	AST_END_NOW: assert property (busy && (b_free || tmo_hit) |=> !ack_reg && state_reg == ST_IDLE) // [RULE6]
		else $error("command not ended at once");
	AST_BAD_PHASE: assert property (state_reg == ST_FIRST && b_req && b_phase != PH_MSG_IN && !AUTO_RECV // [RULE7]
		&& !b_rst && !b_free && !tmo_hit && q_empty |=> cur_reg == rep(CODE_BAD_PHASE, STEP_1))
		else $error("first phase check failed");
	AST_DONE: assert property (state_reg == ST_ACKW && last && !b_req && !b_rst && !b_free && !tmo_hit // [RULE9]
		&& q_empty |=> int_reg && cur_reg == rep(CODE_DONE, STEP_2) && ack_reg == $past(MANUAL_ACK))
		else $error("completion misreported");
	AST_ZERO_COUNT: assert property (cmd_take && !CMD_REG_PERR && cls == CLS_XFER && NEXUS // [RULE10]
		&& MSG_COUNT == 8'h00 && state_reg == ST_IDLE && q_empty |=> cur_reg == rep(CODE_REJECT, STEP_1))
		else $error("zero count not rejected");
	AST_DOUBLE: assert property (busy && CMD_STB |=> dbl_reg) // [RULE13]
		else $error("double command lost");
	AST_UNDEF: assert property (cmd_take && !CMD_REG_PERR && cls == CLS_UNDEF && state_reg == ST_IDLE // [RULE16]
		&& q_empty |=> cur_reg == rep(CODE_REJECT, STEP_0) ##1 int_reg)
		else $error("undefined command not rejected");
	COV_NORMAL: cover property (state_reg == ST_ACKW ##1 state_reg == ST_XFER ##[1:40] state_reg == ST_IDLE);
	COV_HOLD: cover property (state_reg == ST_HOLD ##[1:40] cur_reg.code == CODE_FREE_MID);
	COV_STATUS: cover property (state_reg == ST_STAT ##[1:40] cur_reg.code == CODE_STATUS_IN);
endmodule

/* File: tb/imr_tgt.sv */
// scsi target model for the message-in reporter bench
`timescale 1ns/1ns
module imr_tgt (
	// clock
	input wire logic clk,
	// initiator ack, high = asserted
	input wire logic ack_oe,
	// bus lines, active low
	output imr_pkg::imr_pins_s pins
);
	import imr_pkg::*;
	// terminated lines float high once released; bsy held while connected
	initial pins = 16'hbfff;
	task automatic wait_ack(input logic lvl);
		int n;
		n = 0;
		while (ack_oe !== lvl && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic xfer(input logic [2:0] ph, input logic [7:0] d, input logic bad, input logic hold,
		output logic ok);
		// data and phase settle a cycle before req, so the synchroniser never splits them
		@(posedge clk) pins <= {4'hb, ~ph, (^d) ^ bad, ~d};
		@(posedge clk) pins.req_n <= 1'b0;
		wait_ack(1'b1);
		ok = ack_oe === 1'b1;
		if (!hold) begin
			@(posedge clk) pins.req_n <= 1'b1;
			pins.db_n <= 8'hff;
			pins.dbp_n <= 1'b1;
			wait_ack(1'b0);
		end
	endtask
	task automatic bus_free();
		@(posedge clk) pins <= 16'hffff;
	endtask
	task automatic conn();
		@(posedge clk) pins.bsy_n <= 1'b0;
	endtask
	task automatic bus_rst();
		@(posedge clk) pins <= 16'h7fff;
		repeat (6) @(posedge clk);
		pins <= 16'hffff;
	endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench of the message-in status reporter
`timescale 1ns/1ns
module tb;
	import imr_pkg::*;
	// short timeout keeps the run brief
	localparam int TO = 20;
	typedef struct packed {
		logic [7:0] c;
		logic [7:0] n;
		logic p;
		logic x;
		logic [7:0] ec;
		logic [7:0] es;
	} imr_row_s;
	logic clk, rst, cmd_stb, cmd_perr, auto_recv, manual_ack, nexus, int_ack, rx_ready;
	logic sel_go, int_req, ack_oe, rx_valid, ok;
	logic [7:0] cmd_code, msg_count, rx_data;
	imr_rep_s report;
	imr_pins_s pins;
	int err_count, num_checks, waited, npre;
	logic [7:0] rxq [$];
	imr_row_s rows [13] = '{
		{CMD_RECV_MSG, 8'h01, 2'b11, CODE_REG_PARITY, STEP_0},
		{CMD_RECV_MSG, 8'h01, 2'b10, CODE_REG_PARITY, STEP_0},
		{8'h80, 8'h01, 2'b01, CODE_REJECT, STEP_0},
		{8'hbf, 8'h01, 2'b01, CODE_REJECT, STEP_0},
		{8'h05, 8'h01, 2'b01, CODE_REJECT, STEP_0},
		{8'hff, 8'h01, 2'b01, CODE_REJECT, STEP_0},
		{CMD_RECV_MSG, 8'h01, 2'b00, CODE_REJECT, STEP_0},
		{CMD_SELECT, 8'h01, 2'b01, CODE_REJECT, STEP_0},
		{CMD_SET_ATN, 8'h01, 2'b01, CODE_DONE, STEP_1},
		{CMD_RESET_ATN, 8'h01, 2'b01, CODE_DONE, STEP_1},
		{CMD_SET_ACK, 8'h01, 2'b01, CODE_DONE, STEP_1},
		{CMD_RESET_ACK, 8'h01, 2'b01, CODE_DONE, STEP_1},
		{CMD_RECV_MSG, 8'h00, 2'b01, CODE_REJECT, STEP_1}
	};
	imr_top #(.TIMEOUT(TO), .DEPTH(FIFO_DEPTH)) uut (
		.CLK(clk),
		.RST(rst),
		.CMD_STB(cmd_stb),
		.CMD_CODE(cmd_code),
		.CMD_REG_PERR(cmd_perr),
		.MSG_COUNT(msg_count),
		.AUTO_RECV(auto_recv),
		.MANUAL_ACK(manual_ack),
		.INITIATOR(1'b1),
		.NEXUS(nexus),
		.SEL_GO(sel_go),
		.INT_REQ(int_req),
		.REPORT(report),
		.INT_ACK(int_ack),
		.SCSI_IN(pins),
		.SCSI_ACK_OE(ack_oe),
		.RX_DATA(rx_data),
		.RX_VALID(rx_valid),
		.RX_READY(rx_ready)
	);
	imr_tgt tgt (
		.clk(clk),
		.ack_oe(ack_oe),
		.pins(pins)
	);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back(rx_data);
	end
	task automatic chk(input logic good, input string m);
		num_checks++;
		if (good !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] n, input logic p);
		@(posedge clk) cmd_stb <= 1'b1;
		cmd_code <= c;
		msg_count <= n;
		cmd_perr <= p;
		@(posedge clk) cmd_stb <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] n);
		cmd(CMD_RECV_MSG, n, 1'b0);
	endtask
	// bounded wait for a report, compare it, then read it
	task automatic expect_rep(input logic [7:0] c, input logic [7:0] s);
		waited = 0;
		#1;
		while (int_req !== 1'b1 && waited < 2000) begin
			@(posedge clk);
			#1;
			waited++;
		end
		chk(report === {c, s}, "report pair");
		@(posedge clk) int_ack <= 1'b1;
		@(posedge clk) int_ack <= 1'b0;
	endtask
	// stray ready-state causes after bus upsets are read and dropped
	task automatic flush();
		repeat (10) @(posedge clk);
		#1;
		while (int_req === 1'b1) begin
			@(posedge clk) int_ack <= 1'b1;
			@(posedge clk) int_ack <= 1'b0;
			#1;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		end_of_test();
	end
	initial begin
		rst = 1'b1;
		cmd_stb = 1'b0;
		cmd_code = 8'h00;
		cmd_perr = 1'b0;
		msg_count = 8'h00;
		auto_recv = 1'b0;
		manual_ack = 1'b0;
		nexus = 1'b1;
		int_ack = 1'b0;
		rx_ready = 1'b1;
		err_count = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(int_req === 1'b0 && report === {CODE_DONE, STEP_0} && ack_oe === 1'b0, "reset state");
		chk(rx_valid === 1'b0 && sel_go === 1'b0, "reset outputs");
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			@(posedge clk) nexus <= rows[i].x;
			cmd(rows[i].c, rows[i].n, rows[i].p);
			expect_rep(rows[i].ec, rows[i].es);
			chk(waited <= 1, "late answer");
		end
		@(posedge clk) nexus <= 1'b0;
		cmd(CMD_SELECT, 8'h01, 1'b0);
		#1;
		chk(sel_go === 1'b1 && int_req === 1'b0, "selection refused");
		@(posedge clk) nexus <= 1'b1;
		rxq.delete();
		rc(8'h02);
		tgt.xfer(PH_MSG_IN, 8'h5a, 1'b0, 1'b0, ok);
		tgt.xfer(PH_MSG_IN, 8'ha5, 1'b0, 1'b0, ok);
		expect_rep(CODE_DONE, STEP_2);
		repeat (4) @(posedge clk);
		chk(rxq.size() == 2 && rxq[0] === 8'h5a && rxq[1] === 8'ha5, "rx bytes");
		rc(8'h01);
		tgt.xfer(3'h1, 8'h00, 1'b0, 1'b0, ok);
		expect_rep(CODE_BAD_PHASE, STEP_1);
		@(posedge clk) auto_recv <= 1'b1;
		rc(8'h01);
		tgt.xfer(PH_STATUS, 8'h02, 1'b0, 1'b0, ok);
		expect_rep(CODE_STATUS_IN, STEP_1);
		@(posedge clk) auto_recv <= 1'b0;
		rc(8'h01);
		tgt.xfer(PH_MSG_IN, 8'h11, 1'b1, 1'b0, ok);
		chk(ok === 1'b0, "bad byte acked");
		expect_rep(CODE_PARITY, STEP_1);
		rc(8'h01);
		expect_rep(CODE_TIMEOUT, STEP_1);
		chk(waited >= TO - 2 && waited <= TO + 4, "timeout length");
		rc(8'h02);
		tgt.xfer(PH_MSG_IN, 8'h01, 1'b0, 1'b0, ok);
		tgt.bus_free();
		expect_rep(CODE_FREE_MID, STEP_1);
		chk(waited <= 5, "slow end on free");
		tgt.conn();
		flush();
		rc(8'h02);
		tgt.xfer(PH_MSG_IN, 8'h01, 1'b0, 1'b0, ok);
		tgt.xfer(PH_STATUS, 8'h00, 1'b0, 1'b0, ok);
		expect_rep(CODE_PHASE_CHG, STEP_1);
		chk(ok === 1'b0, "acked after phase change");
		flush();
		for (int i = 0; i < 2; i++) begin
			rc(8'h01);
			if (i > 0)
				tgt.xfer(PH_MSG_IN, 8'h01, 1'b0, 1'b1, ok);
			tgt.bus_free();
			expect_rep(CODE_FREE, 8'(2 * i));
			tgt.conn();
			flush();
		end
		for (int i = 0; i < 3; i++) begin
			rc(i == 1 ? 8'h02 : 8'h01);
			if (i > 0)
				tgt.xfer(PH_MSG_IN, 8'h01, 1'b0, i == 2, ok);
			tgt.bus_rst();
			expect_rep(CODE_RESET, 8'(i));
			tgt.conn();
			flush();
		end
		rc(8'h01);
		cmd(CMD_SET_ATN, 8'h01, 1'b0);
		tgt.xfer(PH_MSG_IN, 8'h01, 1'b0, 1'b0, ok);
		expect_rep(CODE_DONE, STEP_2);
		expect_rep(CODE_DOUBLE, STEP_0);
		@(posedge clk) manual_ack <= 1'b1;
		rc(8'h01);
		tgt.xfer(PH_MSG_IN, 8'h01, 1'b0, 1'b0, ok);
		expect_rep(CODE_DONE, STEP_2);
		chk(ack_oe === 1'b1, "ack not held");
		tgt.bus_free();
		repeat (6) @(posedge clk);
		cmd(CMD_SET_ATN, 8'h01, 1'b0);
		expect_rep(CODE_FREE_MID, STEP_0);
		expect_rep(CODE_DOUBLE, STEP_0);
		@(posedge clk) manual_ack <= 1'b0;
		tgt.conn();
		flush();
		// held ack released by command instead of bus free
		@(posedge clk) manual_ack <= 1'b1;
		rc(8'h01);
		tgt.xfer(PH_MSG_IN, 8'h01, 1'b0, 1'b0, ok);
		expect_rep(CODE_DONE, STEP_2);
		chk(ack_oe === 1'b1, "ack not held before release");
		cmd(CMD_RESET_ACK, 8'h01, 1'b0);
		expect_rep(CODE_DONE, STEP_1);
		chk(ack_oe === 1'b0, "ack not released");
		@(posedge clk) manual_ack <= 1'b0;
		flush();
		// far side stalls for 500 cycles, long enough for the buffer to refuse, then drains it
		rxq.delete();
		npre = 0;
		@(posedge clk) rx_ready <= 1'b0;
		rc(8'h22);
		fork
			begin
				repeat (500) @(posedge clk);
				rx_ready <= 1'b1;
			end
			for (int k = 0; k < 34; k++) begin
				tgt.xfer(PH_MSG_IN, 8'h30 + k[7:0], 1'b0, 1'b0, ok);
				if (ok === 1'b1 && rx_ready === 1'b0)
					npre++;
			end
		join
		expect_rep(CODE_DONE, STEP_2);
		chk(npre >= FIFO_DEPTH && npre <= FIFO_DEPTH + 2, "buffer fill");
		repeat (40) @(posedge clk);
		chk(rxq.size() == 34, "drain count");
		foreach (rxq[k])
			chk(rxq[k] === 8'h30 + k[7:0], "drain order");
		end_of_test();
	end
endmodule
